// file: rtl/follower_pkg.sv
package follower_pkg;

  localparam int CLK_PERIOD_PS    = 5000;
  localparam int SAMPLE_PERIOD_NS = 1000;
  localparam int SAMPLE_CYCLES    = (SAMPLE_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int SAMPLE_CNT_W     = 8;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CMD      = 8'h04;
  localparam logic [7:0] OFS_SETVAL   = 8'h08;
  localparam logic [7:0] OFS_HOMEVAL  = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_ACTPOS   = 8'h14;
  localparam logic [7:0] OFS_CMDPOS   = 8'h18;
  localparam logic [7:0] OFS_PROGCMD  = 8'h1C;
  localparam logic [7:0] OFS_ACTVEL   = 8'h20;
  localparam logic [7:0] OFS_CMDVEL   = 8'h24;
  localparam logic [7:0] OFS_USERDATA = 8'h28;
  localparam logic [7:0] OFS_TRIGPOS  = 8'h2C;
  localparam logic [7:0] OFS_PARAMNUM = 8'h30;

  localparam int CTRL_ARM      = 0;
  localparam int CTRL_SEL_LSB  = 8;
  localparam int CMD_HOME      = 0;
  localparam int CMD_SETPOS    = 1;
  localparam int CMD_EXEC      = 2;
  localparam int CMD_ABORT     = 3;
  localparam int CMD_RETSEL    = 4;
  localparam int CMD_RETPROG   = 5;
  localparam int CMD_ERRCLR    = 6;
  localparam int ST_FOLLOWING  = 0;
  localparam int ST_POSVALID   = 1;
  localparam int ST_ERROR      = 2;
  localparam int ST_MOVING     = 3;
  localparam int ST_USERPROG   = 4;

  localparam logic [31:0] PROG_REF_POS = 32'h0000_0000;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic [7:0]  PARAM_AXIS1  = 8'hE2;
  localparam logic [7:0]  PARAM_AXIS2  = 8'hEA;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] internalInc;
    logic [31:0] internalVel;
    logic [31:0] masterInc;
    logic [31:0] masterVel;
    logic [31:0] posError;
    logic        homeFound;
    logic        moving;
    logic        distanceDone;
    logic        inZone;
  } motion_in_t;

  typedef struct packed {
    logic [31:0] actPos;
    logic [31:0] cmdPos;
    logic [31:0] progCmd;
    logic [31:0] actVel;
    logic [31:0] cmdVel;
    logic [31:0] homeVal;
    logic [31:0] setVal;
    logic [31:0] trigPos;
    logic [31:0] rdData;
    logic [31:0] userData;
    logic        arm;
    logic [4:0]  trigSel;
    logic        userProg;
    logic        posValid;
    logic        statusErr;
    logic        homeStart;
    logic        progStart;
    logic        abortMoves;
    logic        nextMoveOk;
    logic        ready;
    logic        slvErr;
  } state_t;

endpackage : follower_pkg

// file: rtl/sample_tick.sv
`timescale 1ns/10ps
module sample_tick (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick
);
  typedef struct packed {
    logic [follower_pkg::SAMPLE_CNT_W-1:0] count;
    logic                                  tick;
  } tick_state_t;

  tick_state_t s_r;
  tick_state_t s_nxt;

  // Registered tick: every consumer sees the same sample cycle
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.count == follower_pkg::SAMPLE_CNT_W'(follower_pkg::SAMPLE_CYCLES - 1)) begin
      s_nxt.count = '0;
      s_nxt.tick  = 1'b1;
    end else begin
      s_nxt.count = s_r.count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule : sample_tick

// file: rtl/follower_trigger.sv
`timescale 1ns/10ps
module follower_trigger (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        arm,
  input  wire logic [4:0]  trigSel,
  input  wire logic [23:0] ctlIn,
  output logic             following,
  output logic             tripped
);
  typedef struct packed {
    logic [23:0] ctlPrev;
    logic        following;
    logic        tripped;
  } trig_state_t;

  trig_state_t s_r;
  trig_state_t s_nxt;
  logic        level;
  logic        levelPrev;

  // Dropping the arm also stops tracking
  always_comb begin
    level         = (trigSel < 5'h18) ? ctlIn[trigSel] : 1'b0;
    levelPrev     = (trigSel < 5'h18) ? s_r.ctlPrev[trigSel] : 1'b0;
    s_nxt         = s_r;
    s_nxt.ctlPrev = ctlIn;
    s_nxt.tripped = arm && !s_r.following && level && !levelPrev;
    if (!arm) begin
      s_nxt.following = 1'b0;
    end else if (level && !levelPrev) begin
      s_nxt.following = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign following = s_r.following;
  assign tripped   = s_r.tripped;
endmodule : follower_trigger

// file: rtl/follower_position_register_sync.sv
// Function
// - Home refused while following, error flagged
// - Home found unfollowed: load home, resync program
// - Set position loads value, resyncs program
// - No set position while axis moving
// - Program start unfollowed: program = commanded
// - Program start following: program = zero
// - Commanded velocity is internal only
// - Following: actual sums internal and master
// - Commanded position = actual plus error
// - Incremental counts wrap at limit
// - Abort ends all internal moves
// - Return select shows program position
// - Armed trigger starts tracking, flag set
// - Trigger captures commanded position parameter
// - Position valid after homing sync
// - Program position wraps as signed count
// - Following: next move skips in-zone
// - Master counts touch actual and commanded position, never program
// - Axis motion is master plus internal only while following
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
module follower_position_register_sync #(
  parameter int AXIS = 1
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire follower_pkg::apb_req_t   apbReq,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire follower_pkg::motion_in_t motionIn,
  input  wire logic [23:0]              ctlIn,
  output logic                          homeStart,
  output logic                          progStart,
  output logic                          abortMoves,
  output logic                          nextMoveOk,
  output logic                          following,
  output logic                          positionValid,
  output logic                          statusError,
  output logic [31:0]                   actualPos,
  output logic [31:0]                   commandedPos,
  output logic [31:0]                   userData
);
  follower_pkg::state_t s_r;
  follower_pkg::state_t s_nxt;
  logic                 tick;
  logic                 tripped;
  logic                 access;
  logic                 wrCommit;
  logic                 cmdWr;
  logic                 errSet;

  // Two's complement add: counts roll over instead of stopping
  function automatic logic [31:0] addS32(input logic [31:0] a, input logic [31:0] b);
    addS32 = a + b;
  endfunction : addS32

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= follower_pkg::OFS_PARAMNUM);
  endfunction : mapped

  sample_tick u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  follower_trigger u_trig (
    .clk       (clk),
    .reset     (reset),
    .arm       (s_r.arm),
    .trigSel   (s_r.trigSel),
    .ctlIn     (ctlIn),
    .following (following),
    .tripped   (tripped)
  );

  always_comb begin
    access   = apbReq.psel && apbReq.penable;
    wrCommit = access && s_r.ready && apbReq.pwrite && mapped(apbReq.paddr);
    cmdWr    = wrCommit && (apbReq.paddr == follower_pkg::OFS_CMD);
  end

  always_comb begin
    s_nxt            = s_r;
    errSet           = 1'b0;
    s_nxt.homeStart  = 1'b0;
    s_nxt.progStart  = 1'b0;
    s_nxt.abortMoves = 1'b0;
    s_nxt.ready      = 1'b0;
    s_nxt.slvErr     = 1'b0;

    // One wait state gives a registered read word
    if (access && !s_r.ready) begin
      s_nxt.ready  = 1'b1;
      s_nxt.slvErr = !mapped(apbReq.paddr);
      case (apbReq.paddr)
        follower_pkg::OFS_CTRL:     s_nxt.rdData = {19'h0_0000, s_r.trigSel, 7'h00, s_r.arm};
        follower_pkg::OFS_SETVAL:   s_nxt.rdData = s_r.setVal;
        follower_pkg::OFS_HOMEVAL:  s_nxt.rdData = s_r.homeVal;
        follower_pkg::OFS_STATUS:   s_nxt.rdData = {27'h000_0000, s_r.userProg,
                                                    motionIn.moving, s_r.statusErr,
                                                    s_r.posValid, following};
        follower_pkg::OFS_ACTPOS:   s_nxt.rdData = s_r.actPos;
        follower_pkg::OFS_CMDPOS:   s_nxt.rdData = s_r.cmdPos;
        follower_pkg::OFS_PROGCMD:  s_nxt.rdData = s_r.progCmd;
        follower_pkg::OFS_ACTVEL:   s_nxt.rdData = s_r.actVel;
        follower_pkg::OFS_CMDVEL:   s_nxt.rdData = s_r.cmdVel;
        follower_pkg::OFS_USERDATA: s_nxt.rdData = s_r.userData;
        follower_pkg::OFS_TRIGPOS:  s_nxt.rdData = s_r.trigPos;
        follower_pkg::OFS_PARAMNUM: s_nxt.rdData = {24'h00_0000, (AXIS == 2) ?
                                                    follower_pkg::PARAM_AXIS2 :
                                                    follower_pkg::PARAM_AXIS1};
        default:                    s_nxt.rdData = follower_pkg::RESET_WORD;
      endcase
    end

    if (wrCommit) begin
      case (apbReq.paddr)
        follower_pkg::OFS_CTRL: begin
          s_nxt.arm     = apbReq.pwdata[follower_pkg::CTRL_ARM];
          s_nxt.trigSel = apbReq.pwdata[follower_pkg::CTRL_SEL_LSB +: 5];
        end
        follower_pkg::OFS_SETVAL:  s_nxt.setVal  = apbReq.pwdata;
        follower_pkg::OFS_HOMEVAL: s_nxt.homeVal = apbReq.pwdata;
        default: ;
      endcase
    end

    // Per-sample motion; master counts never reach the program registers
    if (tick) begin
      if (following) begin
        s_nxt.actPos = addS32(s_r.actPos, addS32(motionIn.internalInc,
                                                 motionIn.masterInc));
        s_nxt.actVel = addS32(motionIn.internalVel, motionIn.masterVel);
      end else begin
        s_nxt.actPos = addS32(s_r.actPos, motionIn.internalInc);
        s_nxt.actVel = motionIn.internalVel;
      end
      s_nxt.progCmd = addS32(s_r.progCmd, motionIn.internalInc);
      s_nxt.cmdVel  = motionIn.internalVel;
    end

    if (motionIn.homeFound && !following) begin
      s_nxt.actPos   = s_r.homeVal;
      s_nxt.progCmd  = addS32(s_r.homeVal, motionIn.posError);
      s_nxt.posValid = 1'b1;
    end

    if (cmdWr) begin
      if (apbReq.pwdata[follower_pkg::CMD_HOME]) begin
        if (following) begin
          errSet = 1'b1;
        end else begin
          s_nxt.homeStart = 1'b1;
        end
      end
      if (apbReq.pwdata[follower_pkg::CMD_SETPOS]) begin
        if (motionIn.moving) begin
          errSet = 1'b1;
        end else begin
          s_nxt.actPos  = s_r.setVal;
          s_nxt.progCmd = addS32(s_r.setVal, motionIn.posError);
        end
      end
      if (apbReq.pwdata[follower_pkg::CMD_EXEC]) begin
        s_nxt.progStart = 1'b1;
        s_nxt.actPos    = s_r.actPos;
        s_nxt.progCmd   = following ? follower_pkg::PROG_REF_POS
                                    : addS32(s_r.actPos, motionIn.posError);
      end
      if (apbReq.pwdata[follower_pkg::CMD_ABORT]) begin
        s_nxt.abortMoves = 1'b1;
      end
      if (apbReq.pwdata[follower_pkg::CMD_RETSEL]) begin
        s_nxt.userProg = apbReq.pwdata[follower_pkg::CMD_RETPROG];
      end
    end

    // A new error in the clearing cycle survives
    s_nxt.statusErr = errSet || (s_r.statusErr &&
                      !(cmdWr && apbReq.pwdata[follower_pkg::CMD_ERRCLR]));

    if (tripped) begin
      s_nxt.trigPos = s_r.cmdPos;
    end

    s_nxt.cmdPos     = addS32(s_nxt.actPos, motionIn.posError);
    s_nxt.nextMoveOk = motionIn.distanceDone &&
                       (following || motionIn.inZone);
    // Registered so the host word never shows a half-switched mux
    s_nxt.userData   = s_nxt.userProg ? s_nxt.progCmd : s_nxt.actPos;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata        = s_r.rdData;
  assign pready        = s_r.ready;
  assign pslverr       = s_r.slvErr;
  assign homeStart     = s_r.homeStart;
  assign progStart     = s_r.progStart;
  assign abortMoves    = s_r.abortMoves;
  assign nextMoveOk    = s_r.nextMoveOk;
  assign positionValid = s_r.posValid;
  assign statusError   = s_r.statusErr;
  assign actualPos     = s_r.actPos;
  assign commandedPos  = s_r.cmdPos;
  assign userData      = s_r.userData;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_HOME_REFUSED: assert property (
    cmdWr && apbReq.pwdata[follower_pkg::CMD_HOME] && following
    |=> !homeStart && statusError)
    else $error("home accepted while following");

  AST_HOME_LOAD: assert property (
    motionIn.homeFound && !following && !cmdWr
    |=> actualPos == $past(s_r.homeVal) && positionValid)
    else $error("home value not loaded");

  AST_SETPOS_REFUSED: assert property (
    cmdWr && apbReq.pwdata[follower_pkg::CMD_SETPOS] && motionIn.moving && !tick
    && !motionIn.homeFound && !apbReq.pwdata[follower_pkg::CMD_EXEC]
    |=> $stable(actualPos) && $stable(s_r.progCmd) && statusError)
    else $error("set position taken while moving");

  AST_PROG_FOLLOW: assert property (
    cmdWr && apbReq.pwdata[follower_pkg::CMD_EXEC] && following
    |=> s_r.progCmd == follower_pkg::PROG_REF_POS && progStart ##1 !progStart)
    else $error("program position not zeroed");

  AST_CMDPOS_SUM: assert property (
    ##1 commandedPos == actualPos + $past(motionIn.posError))
    else $error("commanded position mismatch");

  AST_CMDVEL: assert property (
    tick |=> s_r.cmdVel == $past(motionIn.internalVel))
    else $error("commanded velocity includes master");

  AST_ACTVEL_SUM: assert property (
    tick && following
    |=> s_r.actVel == $past(motionIn.internalVel) + $past(motionIn.masterVel))
    else $error("actual velocity not summed");

  AST_ABORT: assert property (
    cmdWr && apbReq.pwdata[follower_pkg::CMD_ABORT] |=> abortMoves ##1 !abortMoves)
    else $error("abort pulse wrong");

  AST_TRIG_CAPTURE: assert property (
    tripped |=> s_r.trigPos == $past(commandedPos) && following)
    else $error("trigger position not captured");

  AST_APB_WAIT: assert property (
    access && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  AST_SETPOS_LOAD: assert property (
    cmdWr && apbReq.pwdata[follower_pkg::CMD_SETPOS] && !motionIn.moving
    && !apbReq.pwdata[follower_pkg::CMD_EXEC]
    |=> actualPos == $past(s_r.setVal)
    && s_r.progCmd == $past(s_r.setVal) + $past(motionIn.posError))
    else $error("set position not loaded");

  AST_PROG_RESYNC: assert property (
    cmdWr && apbReq.pwdata[follower_pkg::CMD_EXEC] && !following
    |=> actualPos == $past(actualPos)
    && s_r.progCmd == $past(actualPos) + $past(motionIn.posError))
    else $error("program position not resynchronised");

  AST_PROG_INTERNAL: assert property (
    tick && !cmdWr && !motionIn.homeFound
    |=> s_r.progCmd == $past(s_r.progCmd) + $past(motionIn.internalInc))
    else $error("program position took master counts");

  AST_USER_SELECT: assert property (
    cmdWr && apbReq.pwdata[follower_pkg::CMD_RETSEL]
    && apbReq.pwdata[follower_pkg::CMD_RETPROG]
    |=> userData == s_r.progCmd)
    else $error("user word not program position");

  AST_FOLLOW_START: assert property (
    $rose(following) |-> tripped)
    else $error("tracking began without trigger");

  AST_POS_VALID: assert property (
    $rose(positionValid) |-> $past(motionIn.homeFound) && !$past(following))
    else $error("position valid without home");

  AST_NEXT_MOVE: assert property (
    following && motionIn.distanceDone |=> nextMoveOk)
    else $error("next move waited for zone");

  AST_ERR_SET_WINS: assert property (
    cmdWr && apbReq.pwdata[follower_pkg::CMD_HOME] && following
    && apbReq.pwdata[follower_pkg::CMD_ERRCLR] |=> statusError)
    else $error("home error lost to clear");
endmodule : follower_position_register_sync

// file: test/motion_source.sv
`timescale 1ns/10ps
module motion_source (
  input  wire logic                     clk,
  input  wire logic                     abortMoves,
  input  wire logic                     run,
  input  wire follower_pkg::motion_in_t base,
  output follower_pkg::motion_in_t      mi
);
  logic stopped_r;
  // Aborted motion stays dead until the host drops the move
  always @(posedge clk) stopped_r <= run && (stopped_r || abortMoves);
  always_comb begin
    mi = base;
    mi.moving = run && !stopped_r;
    if (!mi.moving) begin
      mi.internalInc = 32'h0000_0000;
      mi.internalVel = 32'h0000_0000;
    end
  end
endmodule : motion_source

// file: test/follower_position_register_sync_bench.sv
`timescale 1ns/10ps
module follower_position_register_sync_bench;
  logic                     clk = 0, reset = 1, run = 0, e;
  logic [23:0]              ctlIn = '0;
  follower_pkg::apb_req_t   req = '0;
  follower_pkg::motion_in_t base = '0, mi;
  logic [31:0]              prdata, actualPos, commandedPos, userData;
  logic [31:0]              q, a, v, pe, ii, mm, iv, mv, k, seed = 32'h18E32421;
  logic                     pready, pslverr, homeStart, progStart, abortMoves;
  logic                     nextMoveOk, following, positionValid, statusError;
  int                       failCount = 0, samplesChecked = 0, cycles = 0;
  int                       homeCnt = 0, abortCnt = 0, progCnt = 0;

  follower_position_register_sync #(.AXIS(1)) i_dut (.clk(clk), .reset(reset),
    .apbReq(req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .motionIn(mi),
    .ctlIn(ctlIn), .homeStart(homeStart), .progStart(progStart), .abortMoves(abortMoves),
    .nextMoveOk(nextMoveOk), .following(following), .positionValid(positionValid),
    .statusError(statusError), .actualPos(actualPos), .commandedPos(commandedPos),
    .userData(userData));
  motion_source i_src (.clk(clk), .abortMoves(abortMoves), .run(run), .base(base), .mi(mi));

  always #2.5 clk = ~clk;

  task automatic testDone();
    if (failCount == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : testDone

  always @(posedge clk) begin
    cycles++;
    if (homeStart === 1'b1) homeCnt++;
    if (abortMoves === 1'b1) abortCnt++;
    if (progStart === 1'b1) progCnt++;
    if (cycles == 20000) begin
      failCount++;
      testDone();
    end
  end

  function automatic logic [31:0] rnd();
    repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Bus task starts and returns just after a rising edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    // Ends on pready; only the cycle ceiling ends a wait that never sees it
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    req <= '0;
  endtask : apb

  // Second falling edge lets one-cycle pulses reach the counters
  task automatic cmd(input logic [31:0] d);
    apb(1'b1, 8'h04, d);
    repeat (2) @(negedge clk);
  endtask : cmd

  task automatic move();
    logic [31:0] p;
    p = actualPos;
    @(posedge clk);
    base.internalInc <= ii;
    base.masterInc <= mm;
    while (actualPos === p) begin
      @(negedge clk);
    end
    @(posedge clk);
    base.internalInc <= '0;
    base.masterInc <= '0;
    @(negedge clk);
  endtask : move

  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    pe = rnd();
    base.posError <= pe;
    base.distanceDone <= 1'b1;
    apb(1'b0, 8'h10, '0);
    chk(q, 32'h0000_0000, "status after reset");
    apb(1'b0, 8'h34, '0);
    chk({31'h0, e}, 32'h0000_0001, "unmapped error");
    apb(1'b0, 8'h30, '0);
    chk(q, 32'h0000_00E2, "param number");
    v = rnd();
    apb(1'b1, 8'h08, v);
    cmd(32'h0000_0002);
    chk(actualPos, v, "set pos");
    apb(1'b0, 8'h1C, '0);
    chk(q, v + pe, "set pos prog");
    @(posedge clk);
    run <= 1;
    apb(1'b1, 8'h08, ~v);
    cmd(32'h0000_0002);
    chk(actualPos, v, "refused set");
    chk({31'h0, statusError}, 32'h0000_0001, "refused error");
    @(posedge clk);
    run <= 0;
    cmd(32'h0000_0040);
    chk({31'h0, statusError}, 32'h0000_0000, "error clear");
    a = rnd();
    apb(1'b1, 8'h0C, a);
    cmd(32'h0000_0001);
    @(posedge clk);
    base.homeFound <= 1'b1;
    @(posedge clk);
    base.homeFound <= 1'b0;
    repeat (2) @(negedge clk);
    chk(actualPos, a, "home value");
    chk({31'h0, positionValid}, 32'h0000_0001, "pos valid");
    apb(1'b0, 8'h1C, '0);
    chk(q, a + pe, "home prog");
    chk({31'h0, nextMoveOk}, 32'h0000_0000, "needs zone");
    // Corner: count just short of the positive limit must wrap
    apb(1'b1, 8'h08, 32'h7FFF_FFF0);
    cmd(32'h0000_0002);
    ii = 32'h0000_0020;
    mm = rnd();
    iv = rnd();
    @(posedge clk);
    base.internalVel <= iv;
    run <= 1;
    move();
    chk(actualPos, 32'h8000_0010, "wrap actual");
    apb(1'b0, 8'h1C, '0);
    chk(q, 32'h8000_0010 + pe, "wrap prog");
    apb(1'b0, 8'h20, '0);
    chk(q, iv, "unfollowed vel");
    run <= 0;
    a = 32'h8000_0010;
    k = rnd() % 24;
    apb(1'b1, 8'h00, (k << 8) | 32'h0000_0001);
    ctlIn[k[4:0]] <= 1'b1;
    repeat (3) @(negedge clk);
    chk({31'h0, following}, 32'h0000_0001, "following");
    chk({31'h0, nextMoveOk}, 32'h0000_0001, "skip zone");
    apb(1'b0, 8'h2C, '0);
    chk(q, a + pe, "trigger capture");
    cmd(32'h0000_0001);
    chk(homeCnt, 1, "home refused");
    chk({31'h0, statusError}, 32'h0000_0001, "home error");
    cmd(32'h0000_0040);
    cmd(32'h0000_0004);
    apb(1'b0, 8'h1C, '0);
    chk(q, 32'h0000_0000, "prog zero");
    chk(progCnt, 1, "prog start");
    ii = rnd() & 32'h0000_FFFF;
    mm = (rnd() & 32'h0000_FFFF) | 32'h0000_0001;
    mv = rnd();
    base.masterVel <= mv;
    run <= 1;
    move();
    chk(actualPos, a + ii + mm, "combined pos");
    chk(commandedPos, a + ii + mm + pe, "cmd pos");
    apb(1'b0, 8'h1C, '0);
    chk(q, ii, "prog internal only");
    apb(1'b0, 8'h24, '0);
    chk(q, iv, "cmd vel");
    apb(1'b0, 8'h20, '0);
    chk(q, iv + mv, "act vel");
    cmd(32'h0000_0030);
    chk(userData, ii, "user data");
    apb(1'b0, 8'h28, '0);
    chk(q, ii, "user word");
    cmd(32'h0000_0010);
    chk(userData, a + ii + mm, "user actual");
    cmd(32'h0000_0008);
    chk(abortCnt, 1, "abort");
    @(posedge clk);
    run <= 0;
    apb(1'b1, 8'h00, 32'h0000_0000);
    a = a + ii + mm;
    cmd(32'h0000_0004);
    apb(1'b0, 8'h1C, '0);
    chk(q, a + pe, "prog resync");
    chk(actualPos, a, "exec keeps pos");
    chk(progCnt, 2, "prog restart");
    testDone();
  end
endmodule : follower_position_register_sync_bench
